// >>> odd_pkg.sv
// constants, types and encodings shared by the operand descriptor decoder
package odd_pkg;

  localparam logic [3:0] MODE_LIT_MAX   = 4'h3;
  localparam logic [3:0] MODE_REG_IMM_W = 4'h4;
  localparam logic [3:0] MODE_RDEF_IMMH = 4'h5;
  localparam logic [3:0] MODE_FPS_IMMB  = 4'h6;
  localparam logic [3:0] MODE_APS_ABS   = 4'h7;
  localparam logic [3:0] MODE_DISP_W    = 4'h8;
  localparam logic [3:0] MODE_DDEF_W    = 4'h9;
  localparam logic [3:0] MODE_DISP_H    = 4'ha;
  localparam logic [3:0] MODE_DDEF_H    = 4'hb;
  localparam logic [3:0] MODE_DISP_B    = 4'hc;
  localparam logic [3:0] MODE_DDEF_B    = 4'hd;
  localparam logic [3:0] MODE_EXPAND    = 4'he;
  localparam logic [3:0] MODE_NEG_LIT   = 4'hf;

  localparam logic [3:0] REG_FORMAT2 = 4'hb;
  localparam logic [3:0] REG_PC      = 4'hf;
  localparam logic [3:0] FP_REG      = 4'h9;
  localparam logic [3:0] AP_REG      = 4'ha;

  localparam logic [3:0] TYPE_UWORD   = 4'h0;
  localparam logic [3:0] TYPE_UHALF   = 4'h2;
  localparam logic [3:0] TYPE_UBYTE   = 4'h3;
  localparam logic [3:0] TYPE_SWORD   = 4'h4;
  localparam logic [3:0] TYPE_SHALF   = 4'h6;
  localparam logic [3:0] TYPE_SBYTE   = 4'h7;

  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_HALF = 3'h2;
  localparam logic [2:0] LEN_WORD = 3'h4;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } odd_size_t;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_REG  = 3'h1,
    KIND_ADDR = 3'h2,
    KIND_IMM  = 3'h3,
    KIND_LIT  = 3'h4
  } odd_kind_t;

  typedef enum logic [2:0] {
    ST_DESC    = 3'h0,
    ST_COLLECT = 3'h1,
    ST_REG     = 3'h3,
    ST_DEREF   = 3'h2,
    ST_DONE    = 3'h6
  } odd_state_t;

  localparam odd_size_t RST_SIZE   = SZ_WORD;
  localparam logic      RST_SIGNED = 1'b1;

endpackage

// >>> odd_col_if.sv
// carrier between the decoder and its extension-byte collector
`timescale 1ns/10ps
interface odd_col_if;
  logic        clear;
  logic        load;
  logic [7:0]  data;
  logic [2:0]  len;
  logic        sext;
  logic [31:0] value;
  logic [2:0]  count;

  modport main (output clear, output load, output data, output len, output sext,
                input value, input count);
  modport col  (input clear, input load, input data, input len, input sext,
                output value, output count);
endinterface

// >>> odd_collect.sv
// little-endian extension byte collector with sign or zero extension
`timescale 1ns/10ps
module odd_collect
  import odd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  odd_col_if.col   col
);

  logic [31:0] shift_q;
  logic [2:0]  count_q;

  // lowest byte of the stream lands in the lowest lane
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= 32'h0;
      count_q <= 3'h0;
    end else if (col.clear) begin
      shift_q <= 32'h0;
      count_q <= 3'h0;
    end else if (col.load) begin
      shift_q[{count_q[1:0], 3'b000} +: 8] <= col.data; // see RULE10
      count_q <= count_q + 3'h1;
    end
  end

  always_comb begin
    col.value = shift_q;
    if (col.len == LEN_BYTE) begin
      col.value = {{24{col.sext & shift_q[7]}}, shift_q[7:0]}; // see RULE21 see RULE6
    end else if (col.len == LEN_HALF) begin
      col.value = {{16{col.sext & shift_q[15]}}, shift_q[15:0]}; // see RULE6
    end
  end

  assign col.count = count_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_le_first;
    col.load && !col.clear && count_q == 3'h0 |=> shift_q[7:0] == $past(col.data);
  endproperty
  a_le_first: assert property (p_le_first) else $error("first byte not in low lane"); // see RULE10

  property p_le_second;
    col.load && !col.clear && count_q == 3'h1 |=> shift_q[15:8] == $past(col.data);
  endproperty
  a_le_second: assert property (p_le_second) else $error("second byte misplaced"); // see RULE10

  property p_sbyte_ext;
    col.load && !col.clear && count_q == 3'h0 && col.len == LEN_BYTE && col.sext
      |=> col.value[31:8] == {24{$past(col.data[7])}};
  endproperty
  a_sbyte_ext: assert property (p_sbyte_ext) else $error("byte not sign extended"); // see RULE21

endmodule

// >>> odd_decoder.sv
// operand descriptor decoder and effective address generator
// Behaviour
// RULE1: descriptor low nibble selects register, high nibble selects addressing mode.
// RULE2: every operand is decoded from its own descriptor independently.
// RULE3: mode 5 uses register contents as operand address; registers 0-10, 12-14.
// RULE4: register 11 with mode 5 or byte/halfword displacement starts format two.
// RULE5: modes 8, 10, 12 add word, halfword, byte offset to register.
// RULE6: offsets are two's complement; byte and halfword sign extended to 32.
// RULE7: modes 6, 7 use nibble as unsigned offset from frame/argument pointer.
// RULE8: modes 9, 11, 13 read pointer at register plus offset.
// RULE9: register 15 with modes 4, 5, 6 gives 32, 16, 8 bit immediates.
// RULE10: multi-byte stream data assembles little-endian.
// RULE11: short literals 0 to 63 and -1 to -16 need no extra bytes.
// RULE12: modes 0-3 positive literal from byte; mode 15 negative literal.
// RULE13: mode 7 register 15 takes four-byte little-endian absolute address.
// RULE14: mode 14 register 15 reads operand address from embedded address.
// RULE15: expanded operand is type byte with high nibble E, then descriptor.
// RULE16: type codes 7, 6, 4 signed byte/half/word; 3, 2, 0 unsigned.
// RULE17: codes 1, 5, 8-14 reserved; code 15 means absolute deferred.
// RULE18: expanded type persists for later operands until replaced.
// RULE19: expanded type changes immediate signedness, not length; literals untouched.
// RULE20: second descriptor of expanded operand may not be expanded again.
// RULE21: signed byte source replicates bit 7 through 32 bits.
// RULE22: expanded descriptors are rejected on instructions flagged as disallowing them.
// RULE23: reserved or disallowed expansion signals invalid and makes no memory access.
`timescale 1ns/10ps
module odd_decoder
  import odd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              instr_start,
  input  wire logic              instr_no_expand,
  input  wire odd_pkg::odd_size_t instr_size,
  input  wire logic              instr_signed,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  output logic                   byte_ready,
  output logic [3:0]             reg_sel,
  input  wire logic [31:0]       reg_data,
  output logic                   mem_req,
  output logic [31:0]            mem_addr,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  output logic                   op_valid,
  output odd_pkg::odd_kind_t     op_kind,
  output logic [3:0]             op_reg,
  output logic [31:0]            op_addr,
  output logic [31:0]            op_value,
  output odd_pkg::odd_size_t     op_size,
  output logic                   op_signed,
  output logic                   op_invalid,
  output logic                   op_format2
);

  import odd_pkg::*;

  odd_col_if col_if ();

  odd_collect u_collect (
    .clk (clk),
    .rst (rst),
    .col (col_if)
  );

  odd_state_t  st_q;
  odd_state_t  st_d;
  logic        ready_q;
  logic        acc;
  logic        desc_acc;
  logic [3:0]  d_mode;
  logic [3:0]  d_reg;
  logic        d_pc;
  odd_kind_t   d_kind;
  logic [2:0]  d_len;
  logic        d_usereg;
  logic [3:0]  d_sel;
  logic        d_defer;
  logic        d_short;
  logic        d_direct;
  logic        d_sext;
  logic        d_inv;
  logic        d_fmt2;
  logic        d_expand;
  logic [31:0] d_lit;
  logic        d_type_ok;
  odd_size_t   d_type_size;
  logic        d_type_signed;
  odd_kind_t   kind_q;
  logic [2:0]  need_q;
  logic        usereg_q;
  logic        defer_q;
  logic        short_q;
  logic        direct_q;
  logic        sext_q;
  logic        inv_q;
  logic        fmt2_q;
  logic [31:0] lit_q;
  logic [3:0]  nib_q;
  logic        second_q;
  logic        ovr_valid_q;
  odd_size_t   ovr_size_q;
  logic        ovr_signed_q;
  odd_size_t   dflt_size_q;
  logic        dflt_signed_q;
  logic        no_expand_q;
  logic        eff_signed;
  odd_size_t   eff_size;
  logic [31:0] reg_sum;
  logic [31:0] addr_q;
  logic [3:0]  reg_sel_q;
  logic        mem_req_q;
  logic [31:0] mem_addr_q;
  logic        op_valid_q;
  odd_kind_t   op_kind_q;
  logic [3:0]  op_reg_q;
  logic [31:0] op_addr_q;
  logic [31:0] op_value_q;
  odd_size_t   op_size_q;
  logic        op_signed_q;
  logic        op_invalid_q;
  logic        op_format2_q;

  assign acc      = byte_valid && ready_q;
  assign desc_acc = acc && st_q == ST_DESC;
  assign d_mode   = byte_data[7:4]; // see RULE1
  assign d_reg    = byte_data[3:0]; // see RULE1
  assign d_pc     = d_reg == REG_PC;

  // an override decides signedness and reported size, never immediate length; see RULE19
  assign eff_signed = ovr_valid_q ? ovr_signed_q : dflt_signed_q;
  assign eff_size   = ovr_valid_q ? ovr_size_q : dflt_size_q;
  assign reg_sum    = reg_data + (short_q ? {28'h0, nib_q} : col_if.value); // see RULE5

  assign col_if.clear = desc_acc;
  assign col_if.load  = acc && st_q == ST_COLLECT;
  assign col_if.data  = byte_data;
  assign col_if.len   = need_q;
  assign col_if.sext  = sext_q;

  // expanded type codes
  always_comb begin
    d_type_ok     = 1'b1;
    d_type_size   = SZ_WORD;
    d_type_signed = 1'b0;
    case (d_reg)
      TYPE_SBYTE: begin
        d_type_size   = SZ_BYTE; // see RULE16
        d_type_signed = 1'b1;
      end
      TYPE_SHALF: begin
        d_type_size   = SZ_HALF;
        d_type_signed = 1'b1;
      end
      TYPE_SWORD: d_type_signed = 1'b1;
      TYPE_UBYTE: d_type_size = SZ_BYTE;
      TYPE_UHALF: d_type_size = SZ_HALF;
      TYPE_UWORD: d_type_size = SZ_WORD;
      default:    d_type_ok = 1'b0; // see RULE17
    endcase
  end

  // descriptor byte decode
  always_comb begin
    d_kind   = KIND_ADDR;
    d_len    = LEN_NONE;
    d_usereg = 1'b0;
    d_sel    = d_reg;
    d_defer  = 1'b0;
    d_short  = 1'b0;
    d_direct = 1'b0;
    d_sext   = 1'b1;
    d_inv    = 1'b0;
    d_fmt2   = 1'b0;
    d_expand = 1'b0;
    d_lit    = {24'h0, byte_data};
    if (d_mode <= MODE_LIT_MAX) begin
      d_kind = KIND_LIT; // see RULE11 see RULE12
    end else begin
      unique case (d_mode)
        MODE_REG_IMM_W: begin
          d_kind = d_pc ? KIND_IMM : KIND_REG; // see RULE9
          d_len  = d_pc ? LEN_WORD : LEN_NONE;
        end
        MODE_RDEF_IMMH: begin
          if (d_pc) begin
            d_kind = KIND_IMM;
            d_len  = LEN_HALF;
            d_sext = eff_signed; // see RULE19
          end else if (d_reg == REG_FORMAT2) begin
            d_fmt2 = 1'b1; // see RULE4
          end else begin
            d_usereg = 1'b1; // see RULE3
          end
        end
        MODE_FPS_IMMB: begin
          if (d_pc) begin
            d_kind = KIND_IMM;
            d_len  = LEN_BYTE;
            d_sext = eff_signed;
          end else begin
            d_usereg = 1'b1; // see RULE7
            d_short  = 1'b1;
            d_sel    = FP_REG;
          end
        end
        MODE_APS_ABS: begin
          if (d_pc) begin
            d_len    = LEN_WORD; // see RULE13
            d_direct = 1'b1;
          end else begin
            d_usereg = 1'b1; // see RULE7
            d_short  = 1'b1;
            d_sel    = AP_REG;
          end
        end
        MODE_DISP_W, MODE_DDEF_W: begin
          d_inv    = d_reg == REG_FORMAT2;
          d_len    = LEN_WORD; // see RULE5
          d_usereg = 1'b1;
          d_defer  = d_mode[0]; // see RULE8
        end
        MODE_DISP_H, MODE_DDEF_H: begin
          d_fmt2   = d_reg == REG_FORMAT2; // see RULE4
          d_len    = LEN_HALF;
          d_usereg = 1'b1;
          d_defer  = d_mode[0];
        end
        MODE_DISP_B, MODE_DDEF_B: begin
          d_fmt2   = d_reg == REG_FORMAT2;
          d_len    = LEN_BYTE;
          d_usereg = 1'b1;
          d_defer  = d_mode[0];
        end
        MODE_EXPAND: begin
          if (d_pc) begin
            d_len   = LEN_WORD; // see RULE14 see RULE17
            d_defer = 1'b1;
          end else begin
            d_expand = 1'b1; // see RULE15
            d_inv    = !d_type_ok || no_expand_q || second_q; // see RULE22 see RULE20
          end
        end
        MODE_NEG_LIT: begin
          d_kind = KIND_LIT;
          d_lit  = {24'hffffff, byte_data}; // see RULE12
        end
      endcase
    end
    if (d_inv || d_fmt2) begin
      d_kind   = KIND_NONE; // see RULE23
      d_len    = LEN_NONE;
      d_usereg = 1'b0;
      d_defer  = 1'b0;
      d_expand = 1'b0;
    end
    if (d_kind == KIND_IMM && d_len == LEN_WORD) begin
      d_sext = 1'b0;
    end
    if (d_direct || (d_pc && d_mode == MODE_EXPAND)) begin
      d_sext = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_DESC: begin
        if (acc && !d_expand) begin
          if (d_len != LEN_NONE) begin
            st_d = ST_COLLECT;
          end else if (d_usereg) begin
            st_d = ST_REG;
          end else begin
            st_d = ST_DONE;
          end
        end
      end
      ST_COLLECT: begin
        if (acc && col_if.count == need_q - 3'h1) begin
          if (usereg_q) begin
            st_d = ST_REG;
          end else if (defer_q) begin
            st_d = ST_DEREF;
          end else begin
            st_d = ST_DONE;
          end
        end
      end
      ST_REG:   st_d = defer_q ? ST_DEREF : ST_DONE;
      ST_DEREF: st_d = mem_ack ? ST_DONE : ST_DEREF;
      ST_DONE:  st_d = ST_DESC;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= ST_DESC;
      ready_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      ready_q <= st_d == ST_DESC || st_d == ST_COLLECT;
    end
  end

  // per-operand state is reloaded from each fresh descriptor; see RULE2
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kind_q    <= KIND_NONE;
      need_q    <= LEN_NONE;
      usereg_q  <= 1'b0;
      defer_q   <= 1'b0;
      short_q   <= 1'b0;
      direct_q  <= 1'b0;
      sext_q    <= 1'b0;
      inv_q     <= 1'b0;
      fmt2_q    <= 1'b0;
      lit_q     <= 32'h0;
      nib_q     <= 4'h0;
      reg_sel_q <= 4'h0;
    end else if (desc_acc && (!d_expand || d_inv)) begin
      kind_q    <= d_kind;
      need_q    <= d_len;
      usereg_q  <= d_usereg;
      defer_q   <= d_defer;
      short_q   <= d_short;
      direct_q  <= d_direct;
      sext_q    <= d_sext;
      inv_q     <= d_inv;
      fmt2_q    <= d_fmt2;
      lit_q     <= d_lit;
      nib_q     <= d_reg;
      reg_sel_q <= d_sel;
    end
  end

  // type override lasts until the next expansion or instruction; see RULE18
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_valid_q   <= 1'b0;
      ovr_size_q    <= RST_SIZE;
      ovr_signed_q  <= RST_SIGNED;
      second_q      <= 1'b0;
      dflt_size_q   <= RST_SIZE;
      dflt_signed_q <= RST_SIGNED;
      no_expand_q   <= 1'b0;
    end else if (instr_start) begin
      ovr_valid_q   <= 1'b0;
      second_q      <= 1'b0;
      dflt_size_q   <= instr_size;
      dflt_signed_q <= instr_signed;
      no_expand_q   <= instr_no_expand;
    end else if (desc_acc) begin
      second_q <= d_expand;
      if (d_expand) begin
        ovr_valid_q  <= 1'b1; // see RULE18
        ovr_size_q   <= d_type_size;
        ovr_signed_q <= d_type_signed;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q     <= 32'h0;
      mem_req_q  <= 1'b0;
      mem_addr_q <= 32'h0;
    end else begin
      if (st_q == ST_REG) begin
        addr_q <= reg_sum; // see RULE3 see RULE5 see RULE7
      end
      if (st_q != ST_DEREF && st_d == ST_DEREF) begin
        mem_req_q  <= 1'b1; // see RULE8 see RULE14
        // absolute deferred: the top address byte is still on the stream at this edge
        mem_addr_q <= st_q == ST_REG ? reg_sum : {byte_data, col_if.value[23:0]};
      end else if (st_q == ST_DEREF && mem_ack) begin
        mem_req_q <= 1'b0;
        addr_q    <= mem_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_valid_q   <= 1'b0;
      op_kind_q    <= KIND_NONE;
      op_reg_q     <= 4'h0;
      op_addr_q    <= 32'h0;
      op_value_q   <= 32'h0;
      op_size_q    <= RST_SIZE;
      op_signed_q  <= RST_SIGNED;
      op_invalid_q <= 1'b0;
      op_format2_q <= 1'b0;
    end else begin
      op_valid_q <= st_q == ST_DONE;
      if (st_q == ST_DONE) begin
        op_kind_q    <= kind_q;
        op_reg_q     <= reg_sel_q;
        op_addr_q    <= direct_q ? col_if.value : addr_q; // see RULE13
        op_value_q   <= kind_q == KIND_LIT ? lit_q :
                        kind_q == KIND_IMM ? col_if.value : 32'h0; // see RULE10
        op_size_q    <= eff_size;
        op_signed_q  <= eff_signed;
        op_invalid_q <= inv_q; // see RULE23
        op_format2_q <= fmt2_q;
      end
    end
  end

  assign byte_ready = ready_q;
  assign reg_sel    = reg_sel_q;
  assign mem_req    = mem_req_q;
  assign mem_addr   = mem_addr_q;
  assign op_valid   = op_valid_q;
  assign op_kind    = op_kind_q;
  assign op_reg     = op_reg_q;
  assign op_addr    = op_addr_q;
  assign op_value   = op_value_q;
  assign op_size    = op_size_q;
  assign op_signed  = op_signed_q;
  assign op_invalid = op_invalid_q;
  assign op_format2 = op_format2_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_desc(logic [3:0] m);
    desc_acc && !instr_start && byte_data[7:4] == m;
  endsequence

  sequence s_done_valid;
    st_q == ST_DONE ##1 op_valid_q;
  endsequence

  property p_pos_lit;
    s_desc(4'h2) |=> s_done_valid ##0 (op_kind_q == KIND_LIT && op_value_q == {24'h0, $past(byte_data, 2)});
  endproperty
  a_pos_lit: assert property (p_pos_lit) else $error("positive literal wrong"); // see RULE12

  property p_neg_lit;
    s_desc(MODE_NEG_LIT) |=> s_done_valid ##0 (op_value_q == {24'hffffff, $past(byte_data, 2)});
  endproperty
  a_neg_lit: assert property (p_neg_lit) else $error("negative literal wrong"); // see RULE11

  property p_fp_short;
    s_desc(MODE_FPS_IMMB) ##0 !d_pc |=> reg_sel_q == FP_REG ##2
      (op_valid_q && op_addr_q == $past(reg_data, 2) + {28'h0, $past(byte_data[3:0], 3)});
  endproperty
  a_fp_short: assert property (p_fp_short) else $error("frame pointer offset wrong"); // see RULE7

  property p_reg_def;
    s_desc(MODE_RDEF_IMMH) ##0 (!d_pc && d_reg != REG_FORMAT2) |=>
      reg_sel_q == $past(byte_data[3:0]) ##2 (op_valid_q && op_addr_q == $past(reg_data, 2));
  endproperty
  a_reg_def: assert property (p_reg_def) else $error("register deferred address wrong"); // see RULE3

  property p_fmt2;
    s_desc(MODE_DISP_B) ##0 d_reg == REG_FORMAT2 |-> ##2 (op_valid_q && op_format2_q && !mem_req_q);
  endproperty
  a_fmt2: assert property (p_fmt2) else $error("format two not flagged"); // see RULE4

  property p_reserved;
    s_desc(MODE_EXPAND) ##0 (!d_pc && !d_type_ok) |-> (!mem_req_q)[*3] ##0 op_invalid_q;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved type accepted"); // see RULE23

  property p_disallow;
    s_desc(MODE_EXPAND) ##0 (!d_pc && no_expand_q) |-> ##2 (op_valid_q && op_invalid_q);
  endproperty
  a_disallow: assert property (p_disallow) else $error("expansion not rejected"); // see RULE22

  property p_nested;
    s_desc(MODE_EXPAND) ##0 (!d_pc && second_q) |-> ##2 op_invalid_q;
  endproperty
  a_nested: assert property (p_nested) else $error("nested expansion accepted"); // see RULE20

  property p_persist;
    op_valid_q && $past(ovr_valid_q) |-> op_size_q == $past(ovr_size_q) &&
      op_signed_q == $past(ovr_signed_q);
  endproperty
  a_persist: assert property (p_persist) else $error("override type lost"); // see RULE18

  property p_deref;
    st_q == ST_DEREF && mem_ack |=> st_q == ST_DONE ##1 (op_valid_q && op_addr_q == $past(mem_rdata, 2));
  endproperty
  a_deref: assert property (p_deref) else $error("deferred pointer not used"); // see RULE8

endmodule

// >>> odd_far.sv
// far-side model: register contents and pointer memory with adjustable answer delay
`timescale 1ns/10ps
module odd_far (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  wire logic [3:0]  reg_sel,
  output logic      [31:0] reg_data,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [3:0] cnt_q;
  // each register holds a distinct base
  assign reg_data  = 32'h1000_0000 + {20'h0, reg_sel, 8'h00};
  // a pointer reads as the inverse of its address; off-answer data repeats the wait counter, so it changes only during a wait with nonzero dly
  assign mem_rdata = mem_ack ? ~mem_addr : {8{cnt_q}};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 4'h0;
      mem_ack <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        cnt_q   <= (cnt_q == dly) ? 4'h0 : cnt_q + 4'h1;
        mem_ack <= (cnt_q == dly);
      end
    end
  end
endmodule

// >>> odd_decoder_tb.sv
// self-checking bench for the operand descriptor decoder
`timescale 1ns/10ps
module odd_decoder_tb;
  import odd_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, instr_start = 1'b0, instr_no_expand = 1'b0;
  logic        instr_signed = 1'b1, byte_valid = 1'b0, byte_ready, mem_req, mem_ack;
  logic        op_valid, op_signed, op_invalid, op_format2;
  logic [7:0]  byte_data = 8'h00;
  logic [3:0]  reg_sel, op_reg, dly = 4'h0;
  logic [31:0] reg_data, mem_addr, mem_rdata, op_addr, op_value;
  odd_size_t   instr_size = SZ_WORD, op_size;
  odd_kind_t   op_kind;
  int          num_errors = 0, n_tests = 0, n_mem = 0;

  odd_decoder odd_decoder_i (.clk, .rst, .instr_start, .instr_no_expand, .instr_size,
    .instr_signed, .byte_valid, .byte_data, .byte_ready, .reg_sel, .reg_data, .mem_req,
    .mem_addr, .mem_ack, .mem_rdata, .op_valid, .op_kind, .op_reg, .op_addr, .op_value,
    .op_size, .op_signed, .op_invalid, .op_format2);
  odd_far odd_far_i (.clk, .rst, .dly, .reg_sel, .reg_data, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata);

  always #5 clk = ~clk;
  always @(posedge clk) n_mem += (mem_req === 1'b1);

  function automatic logic [31:0] rv(input logic [3:0] n);
    return 32'h1000_0000 + {20'h0, n, 8'h00};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic start(input logic ne, input odd_size_t sz, input logic sg);
    instr_no_expand = ne;
    instr_size = sz;
    instr_signed = sg;
    instr_start = 1'b1;
    @(posedge clk) #1;
    instr_start = 1'b0;
  endtask

  // bytes go out lowest first, valid held across the whole run
  task automatic op(input logic [47:0] bs, input int n, input odd_kind_t k,
                    input logic [31:0] v, input logic [1:0] f);
    byte_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      byte_data = bs[8*i +: 8];
      while (byte_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
    end
    byte_valid = 1'b0;
    for (int i = 0; i < 40 && op_valid !== 1'b1; i++) @(posedge clk) #1;
    chk({31'h0, op_valid}, 32'h1);
    chk({29'h0, op_kind}, {29'h0, k});
    chk({30'h0, op_invalid, op_format2}, {30'h0, f});
    if (k == KIND_ADDR) chk(op_addr, v);
    else if (k != KIND_NONE && k != KIND_REG) chk(op_value, v);
    else if (k == KIND_REG) chk({28'h0, op_reg}, v);
    @(posedge clk) #1;
  endtask

  task automatic t_lit;
    logic [7:0]  d[4] = '{8'h25, 8'h3f, 8'hff, 8'hf0};
    logic [31:0] e[4] = '{32'h25, 32'h3f, 32'hffff_ffff, 32'hffff_fff0};
    start(1'b0, SZ_WORD, 1'b1);
    foreach (d[i]) op({40'h0, d[i]}, 1, KIND_LIT, e[i], 2'b00);
  endtask

  task automatic t_addr;
    op(48'h52, 1, KIND_ADDR, rv(2), 2'b00);
    op(48'h80c2, 2, KIND_ADDR, rv(2) + 32'hffff_ff80, 2'b00);
    op(48'h8234a3, 3, KIND_ADDR, rv(3) + 32'hffff_8234, 2'b00);
    op(48'h12_3456_7884, 5, KIND_ADDR, rv(4) + 32'h1234_5678, 2'b00);
    op(48'h63, 1, KIND_ADDR, rv(9) + 32'h3, 2'b00);
    op(48'h7e, 1, KIND_ADDR, rv(10) + 32'he, 2'b00);
    op(48'h12_3456_787f, 5, KIND_ADDR, 32'h1234_5678, 2'b00);
    op(48'h5b, 1, KIND_NONE, 32'h0, 2'b01);
    op(48'h8b, 1, KIND_NONE, 32'h0, 2'b10);
    op(48'hcb, 1, KIND_NONE, 32'h0, 2'b01);
  endtask

  task automatic t_defer;
    op(48'h00_0000_0492, 5, KIND_ADDR, ~(rv(2) + 32'h4), 2'b00);
    dly = 4'h6;
    op(48'hf0d3, 2, KIND_ADDR, ~(rv(3) + 32'hffff_fff0), 2'b00);
    op(48'h12_342e_04ef, 5, KIND_ADDR, ~32'h1234_2e04, 2'b00);
  endtask

  task automatic t_imm;
    op(48'h806f, 2, KIND_IMM, 32'hffff_ff80, 2'b00);
    op(48'habcd5f, 3, KIND_IMM, 32'hffff_abcd, 2'b00);
    op(48'h12_3456_784f, 5, KIND_IMM, 32'h1234_5678, 2'b00);
    op(48'h806fe3, 3, KIND_IMM, 32'h80, 2'b00);
    op(48'h806f, 2, KIND_IMM, 32'h80, 2'b00);
    op(48'hff, 1, KIND_LIT, 32'hffff_ffff, 2'b00);
    start(1'b0, SZ_WORD, 1'b1);
    op(48'h806f, 2, KIND_IMM, 32'hffff_ff80, 2'b00);
  endtask

  task automatic t_exp;
    logic [7:0] c[6] = '{8'he7, 8'he6, 8'he4, 8'he3, 8'he2, 8'he0};
    logic [2:0] t[6] = '{3'b001, 3'b011, 3'b101, 3'b000, 3'b010, 3'b100};
    logic [7:0] r[4] = '{8'he1, 8'he5, 8'he8, 8'hee};
    int         k;
    foreach (c[i]) begin
      op({32'h0, 8'h43, c[i]}, 2, KIND_REG, 32'h3, 2'b00);
      chk({29'h0, op_size, op_signed}, {29'h0, t[i]});
    end
    k = n_mem;
    foreach (r[i]) op({40'h0, r[i]}, 1, KIND_NONE, 32'h0, 2'b10);
    op(48'he0e4, 2, KIND_NONE, 32'h0, 2'b10);
    start(1'b1, SZ_WORD, 1'b1);
    op(48'he7, 1, KIND_NONE, 32'h0, 2'b10);
    chk(n_mem, k);
    op(48'h52, 1, KIND_ADDR, rv(2), 2'b00);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    t_lit();
    t_addr();
    t_defer();
    t_imm();
    t_exp();
    give_verdict();
  end

  initial begin
    #60000;
    num_errors++;
    give_verdict();
  end
endmodule
